//--- lsc_pkg.sv
// Purpose: shared constants for the load switch and spare configuration bank
// Assumes: classic wishbone slave, 32-bit data, byte addresses are four times the printed index
// Notes: all offsets, fields, reset values and timing counts live here
package lsc_pkg;
   // ==========================================================
   // register indices and byte addresses
   localparam logic [7:0] LSC_IDX_LOAD_SWITCH = 8'h62;
   localparam logic [7:0] LSC_IDX_SPARE = 8'h63;
   localparam logic [9:0] LSC_ADDR_LOAD_SWITCH = {LSC_IDX_LOAD_SWITCH, 2'b00};
   localparam logic [9:0] LSC_ADDR_SPARE = {LSC_IDX_SPARE, 2'b00};
   localparam logic [9:0] LSC_ADDR_STATUS = 10'h200;
   // ==========================================================
   // field positions
   localparam int LSC_MODE_LSB = 0;
   localparam int LSC_CURRENT_LIMIT_SEL_LSB = 2;
   localparam int LSC_OD_BIT = 0;
   localparam int LSC_SKIP_BIT = 1;
   localparam int LSC_SELD_BIT = 2;
   localparam int LSC_OSCG_BIT = 3;
   // ==========================================================
   // reset values
   localparam logic [1:0] LSC_MODE_RST = 2'h0;
   localparam logic [1:0] LSC_CURRENT_LIMIT_SEL_RST = 2'h1;
   localparam logic [3:0] LSC_SPARE_RST = 4'h0;
   // ==========================================================
   // switch modes
   typedef enum logic [1:0] {
      LSC_SW_OFF = 2'b00,
      LSC_SW_ON = 2'b01,
      LSC_SW_BYP_AUTO = 2'b10,
      LSC_SW_BYP_ON = 2'b11
   } lsc_mode_t;
   // ==========================================================
   // current limits in mA
   localparam logic [11:0] LSC_CURRENT_LIMIT_SEL_MA_0 = 12'h064;
   localparam logic [11:0] LSC_CURRENT_LIMIT_SEL_MA_1 = 12'h1f4;
   localparam logic [11:0] LSC_CURRENT_LIMIT_SEL_MA_2 = 12'h2ee;
   localparam logic [11:0] LSC_CURRENT_LIMIT_SEL_MA_3 = 12'h9c4;
   // ==========================================================
   // timing: 32 kHz tick derived from the 200 MHz clock
   localparam int LSC_CLK_HZ = 200000000;
   localparam int LSC_SLOW_HZ = 32768;
   localparam int LSC_SLOW_DIV = LSC_CLK_HZ / LSC_SLOW_HZ;
endpackage

//--- lsc_sync.sv
// Purpose: three-stage synchroniser with agreement filter for one pin
// Assumes: input is asynchronous to ref_clk_i
// Notes: output changes once the second and third stages agree
`timescale 1ns/100ps
module lsc_sync (
   input wire logic ref_clk_i, // system clock
   input wire logic arst_n_i, // async reset, active low
   input wire logic pin_i, // raw pin
   output logic level_o // filtered level
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
   } lsc_sync_t;
   lsc_sync_t st;
   lsc_sync_t next_st;

   // shift chain; first stage feeds only the second
   always_comb begin
      next_st = st;
      next_st.s1 = pin_i;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      if (st.s2 == st.s3) begin
         next_st.lvl = st.s3;
      end
   end

   // state register
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign level_o = st.lvl;
endmodule

//--- lsc_tick.sv
// Purpose: divider producing a one-cycle enable at the slow clock rate
// Assumes: DIV at least 2
// Notes: used to time the select-pin falling delay
`timescale 1ns/100ps
module lsc_tick #(
   parameter int DIV = 6103
) (
   input wire logic ref_clk_i, // system clock
   input wire logic arst_n_i, // async reset, active low
   output logic tick_o // one-cycle pulse
);
   typedef struct packed {
      logic [15:0] cnt;
      logic tick;
   } lsc_tick_t;
   lsc_tick_t st;
   lsc_tick_t next_st;

   // free-running count
   always_comb begin
      next_st = st;
      next_st.tick = 1'b0;
      if (st.cnt == 16'(DIV - 1)) begin
         next_st.cnt = 16'h0000;
         next_st.tick = 1'b1;
      end else begin
         next_st.cnt = st.cnt + 16'h0001;
      end
   end

   // state register
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign tick_o = st.tick;
endmodule

//--- lsc_bank.sv
// Purpose: load switch control and spare configuration registers with their control outputs
// Assumes: classic wishbone slave; comparator and pins are asynchronous inputs
// Notes: answer one cycle after request; unmapped reads return zero and are acknowledged
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/100ps

// Functional notes
// - mode 00 keeps switch off, mode 01 forces it on
// - mode 10 is bypass, switch enable follows buck-4 comparator request
// - mode 11 is bypass with switch held on
// - both bypass modes block buck-4 forced PWM
// - overvoltage in bypass clears the mode field to 00
// - current limit code decodes to 100, 500, 750 or 2500 mA
// - reserved and unused bits read as zero
// - clock output push-pull when bit is 0, open drain when 1
// - skip bit 0 means buck-4 voltage changes use slew step
// - skip bit 1 applies buck-4 voltage changes immediately
// - select-pin falling change delayed half to one slow period
// - delay disable bit makes select-pin changes act at once
// - gating bit 0 keeps fast oscillator running
// - gating bit 1 stops oscillator only when both request pins low
// - reset returns both registers to reset values, spare fields zero
module lsc_bank #(
   parameter int SLOW_DIV = lsc_pkg::LSC_SLOW_DIV,
   parameter logic [1:0] CURRENT_LIMIT_SEL_RESET = lsc_pkg::LSC_CURRENT_LIMIT_SEL_RST
) (
   input wire logic ref_clk_i, // 200 MHz clock
   input wire logic arst_n_i, // async reset, active low
   input wire logic wb_cyc_i, // wishbone cycle
   input wire logic wb_stb_i, // wishbone strobe
   input wire logic wb_we_i, // wishbone write
   input wire logic [9:0] wb_adr_i, // byte address
   input wire logic [3:0] wb_sel_i, // byte selects
   input wire logic [31:0] wb_dat_i, // write data
   output logic [31:0] wb_dat_o, // read data
   output logic wb_ack_o, // acknowledge
   input wire logic ovp_i, // buck-4 output sense overvoltage comparator
   input wire logic cmp_en_i, // buck-4 comparator switch request
   input wire logic power_request_pin_i, // power request pin
   input wire logic clock_request_pin_i, // clock request pin
   input wire logic buck4_select_pin_i, // buck-4 select pin
   output logic switch_on_o, // load switch gate enable
   output logic bypass_o, // bypass operation active
   output logic pwm_block_o, // block buck-4 forced pwm
   output logic [11:0] current_limit_sel_ma_o, // current limit in mA
   output logic clk_out_open_drain_o, // 32 kHz driver open drain
   output logic buck4_skip_slew_o, // buck-4 changes bypass slew
   output logic buck4_select_o, // select level applied to buck-4
   output logic fast_osc_en_o // 9 MHz oscillator enable
);
   typedef struct packed {
      logic [1:0] mode;
      logic [1:0] current_limit_sel;
      logic [3:0] spare;
      logic [31:0] rdata;
      logic ack;
      logic sw_on;
      logic byp;
      logic pwm_blk;
      logic [11:0] current_limit_sel_ma;
      logic od;
      logic skip;
      logic sel;
      logic [1:0] dcnt;
      logic osc;
   } lsc_bank_t;
   lsc_bank_t st;
   lsc_bank_t next_st;
   logic ovp_s;
   logic cmp_s;
   logic preq_s;
   logic creq_s;
   logic sel_s;
   logic slow_tick;
   logic bus_req;
   logic in_bypass;

   // ==========================================================
   // synchronisers and slow tick
   lsc_sync u_sync_ovp (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .pin_i(ovp_i), .level_o(ovp_s));
   lsc_sync u_sync_cmp (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .pin_i(cmp_en_i), .level_o(cmp_s));
   lsc_sync u_sync_preq (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .pin_i(power_request_pin_i),
      .level_o(preq_s));
   lsc_sync u_sync_creq (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .pin_i(clock_request_pin_i),
      .level_o(creq_s));
   lsc_sync u_sync_sel (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .pin_i(buck4_select_pin_i),
      .level_o(sel_s));
   // half-period tick: the second one after a fall lands within half to one slow period
   lsc_tick #(.DIV(SLOW_DIV / 2)) u_tick (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .tick_o(slow_tick));

   assign bus_req = wb_cyc_i & wb_stb_i & ~st.ack;
   assign in_bypass = st.mode[1];

   // ==========================================================
   // next state
   always_comb begin
      next_st = st;
      next_st.ack = bus_req;
      // register writes take effect with the acknowledge
      if (bus_req && wb_we_i && wb_sel_i[0]) begin
         if (wb_adr_i == lsc_pkg::LSC_ADDR_LOAD_SWITCH) begin
            next_st.mode = wb_dat_i[lsc_pkg::LSC_MODE_LSB +: 2];
            next_st.current_limit_sel = wb_dat_i[lsc_pkg::LSC_CURRENT_LIMIT_SEL_LSB +: 2];
         end
         if (wb_adr_i == lsc_pkg::LSC_ADDR_SPARE) begin
            next_st.spare = wb_dat_i[3:0];
         end
      end
      // overvoltage in bypass wins over a write
      if (in_bypass && ovp_s) begin
         next_st.mode = lsc_pkg::LSC_MODE_RST;
      end
      // read mux; unused bits zero
      next_st.rdata = 32'h0000_0000;
      if (bus_req && !wb_we_i) begin
         case (wb_adr_i)
            lsc_pkg::LSC_ADDR_LOAD_SWITCH: next_st.rdata = {28'h000_0000, st.current_limit_sel, st.mode};
            lsc_pkg::LSC_ADDR_SPARE: next_st.rdata = {28'h000_0000, st.spare};
            lsc_pkg::LSC_ADDR_STATUS: next_st.rdata = {26'h000_0000, st.osc, st.sel, cmp_s, ovp_s, st.byp,
               st.sw_on};
            default: next_st.rdata = 32'h0000_0000;
         endcase
      end
      // switch mode decode
      case (lsc_pkg::lsc_mode_t'(st.mode))
         lsc_pkg::LSC_SW_OFF: next_st.sw_on = 1'b0;
         lsc_pkg::LSC_SW_ON: next_st.sw_on = 1'b1;
         lsc_pkg::LSC_SW_BYP_AUTO: next_st.sw_on = cmp_s & ~ovp_s;
         lsc_pkg::LSC_SW_BYP_ON: next_st.sw_on = ~ovp_s;
         default: next_st.sw_on = 1'b0;
      endcase
      next_st.byp = in_bypass & ~ovp_s;
      next_st.pwm_blk = in_bypass;
      // current limit decode
      case (st.current_limit_sel)
         2'b00: next_st.current_limit_sel_ma = lsc_pkg::LSC_CURRENT_LIMIT_SEL_MA_0;
         2'b01: next_st.current_limit_sel_ma = lsc_pkg::LSC_CURRENT_LIMIT_SEL_MA_1;
         2'b10: next_st.current_limit_sel_ma = lsc_pkg::LSC_CURRENT_LIMIT_SEL_MA_2;
         default: next_st.current_limit_sel_ma = lsc_pkg::LSC_CURRENT_LIMIT_SEL_MA_3;
      endcase
      next_st.od = st.spare[lsc_pkg::LSC_OD_BIT];
      next_st.skip = st.spare[lsc_pkg::LSC_SKIP_BIT];
      // select pin: rise at once, fall on the second half-period tick unless delay disabled
      if (sel_s || st.spare[lsc_pkg::LSC_SELD_BIT]) begin
         next_st.sel = sel_s;
         next_st.dcnt = 2'h0;
      end else if (st.sel) begin
         if (slow_tick) begin
            if (st.dcnt == 2'h1) begin
               next_st.sel = 1'b0;
               next_st.dcnt = 2'h0;
            end else begin
               next_st.dcnt = st.dcnt + 2'h1;
            end
         end
      end
      // fast oscillator gating
      if (st.spare[lsc_pkg::LSC_OSCG_BIT]) begin
         next_st.osc = preq_s | creq_s;
      end else begin
         next_st.osc = 1'b1;
      end
   end

   // ==========================================================
   // state register
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st <= '0;
         st.current_limit_sel <= CURRENT_LIMIT_SEL_RESET;
         st.osc <= 1'b1;
         st.current_limit_sel_ma <= lsc_pkg::LSC_CURRENT_LIMIT_SEL_MA_1;
      end else begin
         st <= next_st;
      end
   end

   assign wb_dat_o = st.rdata;
   assign wb_ack_o = st.ack;
   assign switch_on_o = st.sw_on;
   assign bypass_o = st.byp;
   assign pwm_block_o = st.pwm_blk;
   assign current_limit_sel_ma_o = st.current_limit_sel_ma;
   assign clk_out_open_drain_o = st.od;
   assign buck4_skip_slew_o = st.skip;
   assign buck4_select_o = st.sel;
   assign fast_osc_en_o = st.osc;

   // ==========================================================
   // assertions
   ovp_clear_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      (st.mode[1] && ovp_s) |=> (st.mode == 2'b00))
      else $error("mode not cleared on overvoltage");
   sw_off_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      (st.mode == 2'b00) |=> !st.sw_on)
      else $error("switch on in off mode");
   sw_forced_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      (st.mode == 2'b01) |=> st.sw_on)
      else $error("switch off in forced mode");
   byp_auto_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      (st.mode == 2'b10 && !ovp_s) |=> (st.sw_on == $past(cmp_s)))
      else $error("auto bypass not following comparator");
   byp_on_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      (st.mode == 2'b11 && !ovp_s) |=> st.sw_on)
      else $error("bypass switch not forced on");
   pwm_block_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      1'b1 |=> (st.pwm_blk == $past(st.mode[1])))
      else $error("pwm block wrong");
   current_limit_sel_dec_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      (st.current_limit_sel == 2'b10) |=> (st.current_limit_sel_ma == 12'h2ee))
      else $error("current limit decode wrong");
   rsvd_zero_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      st.ack |-> (st.rdata[31:6] == 26'h000_0000))
      else $error("reserved bits not zero");
   osc_run_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      !st.spare[3] |=> st.osc)
      else $error("oscillator stopped with gating off");
   osc_gate_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      (st.spare[3] && !preq_s && !creq_s) |=> !st.osc)
      else $error("oscillator not stopped");
   sel_nodly_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      st.spare[2] |=> (st.sel == $past(sel_s)))
      else $error("select delayed with delay off");
   sel_hold_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      (!st.spare[2] && st.sel && !sel_s && !slow_tick) |=> st.sel)
      else $error("select fell without slow tick");
   ack_once_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      st.ack |=> !st.ack)
      else $error("ack longer than one cycle");
   od_copy_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      1'b1 |=> (st.od == $past(st.spare[0])))
      else $error("open drain select not following spare bit");
   skip_copy_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      1'b1 |=> (st.skip == $past(st.spare[1])))
      else $error("slew skip not following spare bit");
   sel_tick_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      ($fell(st.sel) && !$past(st.spare[2])) |-> $past(slow_tick))
      else $error("select fell away from the slow tick");
   byp_flag_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      1'b1 |=> (st.byp == ($past(st.mode[1]) && !$past(ovp_s))))
      else $error("bypass flag wrong");

   write_c: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i) st.ack && wb_we_i);
   ovp_c: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i) st.mode[1] && ovp_s);
   sel_fall_c: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i) $fell(st.sel));
   osc_off_c: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i) $fell(st.osc));
endmodule

//--- lsc_host_model.sv
// Purpose: host side model issuing classic wishbone single cycles
// Assumes: slave answers each request with a one-cycle ack
// Notes: every wait is bounded; ok low reports a missing answer
`timescale 1ns/100ps
module lsc_host_model (
   input wire logic ref_clk_i, // system clock
   input wire logic wb_ack_i, // acknowledge from slave
   input wire logic [31:0] wb_dat_i, // read data from slave
   output logic wb_cyc_o, // cycle
   output logic wb_stb_o, // strobe
   output logic wb_we_o, // write enable
   output logic [9:0] wb_adr_o, // byte address
   output logic [3:0] wb_sel_o, // byte selects
   output logic [31:0] wb_dat_o // write data
);
   // ==========================================================
   // idle bus at time zero
   initial begin
      wb_cyc_o = 1'b0;
      wb_stb_o = 1'b0;
      wb_we_o = 1'b0;
      wb_adr_o = 10'h000;
      wb_sel_o = 4'h0;
      wb_dat_o = 32'h0000_0000;
   end
   // ==========================================================
   // one cycle, held until ack is sampled high at a rising edge
   task automatic access(input logic we, input logic [9:0] adr, input logic [31:0] wd,
                         output logic [31:0] rd, output bit ok);
      int i;
      ok = 1'b0;
      rd = 32'h0000_0000;
      @(posedge ref_clk_i);
      wb_cyc_o <= 1'b1;
      wb_stb_o <= 1'b1;
      wb_we_o <= we;
      wb_adr_o <= adr;
      wb_sel_o <= 4'hf;
      wb_dat_o <= wd;
      for (i = 0; i < 50; i++) begin
         @(posedge ref_clk_i);
         if (wb_ack_i === 1'b1) begin
            rd = wb_dat_i;
            ok = 1'b1;
            break;
         end
      end
      // released data lines show no stale value
      wb_cyc_o <= 1'b0;
      wb_stb_o <= 1'b0;
      wb_we_o <= 1'b0;
      wb_dat_o <= ~wd;
   endtask
endmodule

//--- testbench.sv
// Purpose: self-checking bench for the load switch and spare configuration bank
// Assumes: bank acks one cycle after a request; pins settle within eight cycles
// Notes: slow divider shortened to 8 cycles
`timescale 1ns/100ps
module testbench;
   localparam logic [9:0] LS = lsc_pkg::LSC_ADDR_LOAD_SWITCH;
   localparam logic [9:0] SP = lsc_pkg::LSC_ADDR_SPARE;
   logic ref_clk_i, arst_n_i, cyc, stb, we, ack, ovp, cmp_en, power_request_pin, clk_req, sel_pin;
   logic sw_on, byp, pwm_blk, od, skip, sel_out, osc_en;
   logic [9:0] adr;
   logic [3:0] sel;
   logic [31:0] dat_w, dat_r;
   logic [11:0] current_limit_sel_ma;
   int n_mismatch, num_checks;
   lsc_host_model u_host (.ref_clk_i(ref_clk_i), .wb_ack_i(ack), .wb_dat_i(dat_r), .wb_cyc_o(cyc),
      .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(dat_w));
   lsc_bank #(.SLOW_DIV(8)) u_dut (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
      .wb_ack_o(ack), .ovp_i(ovp), .cmp_en_i(cmp_en), .power_request_pin_i(power_request_pin),
      .clock_request_pin_i(clk_req), .buck4_select_pin_i(sel_pin), .switch_on_o(sw_on), .bypass_o(byp),
      .pwm_block_o(pwm_blk), .current_limit_sel_ma_o(current_limit_sel_ma), .clk_out_open_drain_o(od), .buck4_skip_slew_o(skip),
      .buck4_select_o(sel_out), .fast_osc_en_o(osc_en));
   // ==========================================================
   // 200 MHz clock
   initial begin
      ref_clk_i = 1'b0;
      forever #2.5 ref_clk_i = ~ref_clk_i;
   end
   // ==========================================================
   // verdict and compare helpers
   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cycles(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask
   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      logic [31:0] r;
      bit ok;
      u_host.access(1'b1, a, d, r, ok);
      if (!ok) begin
         n_mismatch++;
         stop_test();
      end
   endtask
   task automatic rd_chk(input string what, input logic [9:0] a, input logic [31:0] exp);
      logic [31:0] r;
      bit ok;
      u_host.access(1'b0, a, 32'h0000_0000, r, ok);
      if (!ok) begin
         n_mismatch++;
         stop_test();
      end
      chk(what, exp, r);
   endtask
   // ==========================================================
   // scenarios
   task automatic t_reset;
      rd_chk("ls reset", LS, 32'h0000_0004);
      rd_chk("spare reset", SP, 32'h0000_0000);
      rd_chk("status reset", lsc_pkg::LSC_ADDR_STATUS, 32'h0000_0020);
      chk("sw reset", 32'(1'b0), 32'(sw_on));
      chk("osc reset", 32'(1'b1), 32'(osc_en));
   endtask
   task automatic t_modes;
      logic [1:0] m;
      for (int i = 0; i < 8; i++) begin
         m = i[2:1];
         wr(LS, {28'h000_0000, 2'b01, m});
         cmp_en <= i[0];
         cycles(8);
         chk("switch on", 32'((m == 2'b01) || (m == 2'b11) || (m == 2'b10 && i[0])), 32'(sw_on));
         chk("bypass", 32'(m[1]), 32'(byp));
         chk("pwm block", 32'(m[1]), 32'(pwm_blk));
      end
      cmp_en <= 1'b0;
   endtask
   task automatic t_current_limit_sel;
      logic [11:0] exp[4] = '{12'h064, 12'h1f4, 12'h2ee, 12'h9c4};
      for (int i = 0; i < 4; i++) begin
         wr(LS, {28'h000_0000, i[1:0], 2'b00});
         cycles(2);
         chk("current_limit_sel", 32'(exp[i]), 32'(current_limit_sel_ma));
      end
   endtask
   task automatic t_reserved;
      wr(LS, 32'hffff_ffff);
      rd_chk("ls reserved", LS, 32'h0000_000f);
      wr(SP, 32'hffff_fff0);
      rd_chk("spare reserved", SP, 32'h0000_0000);
      wr(10'h3fc, 32'hffff_ffff);
      rd_chk("unmapped", 10'h3fc, 32'h0000_0000);
      rd_chk("spare kept", SP, 32'h0000_0000);
   endtask
   task automatic t_ovp;
      for (int m = 2; m < 4; m++) begin
         wr(LS, {28'h000_0000, 2'b01, m[1:0]});
         cmp_en <= 1'b1;
         cycles(8);
         chk("bypass on", 32'h0000_0001, 32'(sw_on));
         ovp <= 1'b1;
         cycles(8);
         rd_chk("ovp clear", LS, 32'h0000_0004);
         chk("ovp switch", 32'h0000_0000, 32'(sw_on));
         chk("ovp bypass", 32'h0000_0000, 32'(byp));
         rd_chk("ovp status", lsc_pkg::LSC_ADDR_STATUS, 32'h0000_002c);
         ovp <= 1'b0;
         cmp_en <= 1'b0;
         // let the synchronised comparator fall before the next bypass write
         cycles(8);
      end
   endtask
   task automatic t_spare_bits;
      wr(SP, 32'h0000_0001);
      cycles(2);
      chk("open drain", 32'h0000_0001, 32'(od));
      chk("skip off", 32'h0000_0000, 32'(skip));
      wr(SP, 32'h0000_0002);
      cycles(2);
      chk("push pull", 32'h0000_0000, 32'(od));
      chk("skip on", 32'h0000_0001, 32'(skip));
   endtask
   task automatic t_osc;
      for (int i = 0; i < 8; i++) begin
         wr(SP, {28'h000_0000, i[2], 3'b000});
         power_request_pin <= i[1];
         clk_req <= i[0];
         cycles(8);
         chk("osc enable", 32'(!i[2] || (i[1:0] != 2'b00)), 32'(osc_en));
      end
   endtask
   task automatic t_select;
      int n;
      for (int i = 0; i < 2; i++) begin
         wr(SP, {28'h000_0000, 1'b0, i[0], 2'b00});
         sel_pin <= 1'b1;
         cycles(8);
         chk("select high", 32'h0000_0001, 32'(sel_out));
         sel_pin <= 1'b0;
         cycles(7);
         chk("select fall", 32'(!i[0]), 32'(sel_out));
         for (n = 0; n < 40 && sel_out !== 1'b0; n++) begin
            @(posedge ref_clk_i);
         end
         chk("select low", 32'h0000_0000, 32'(sel_out));
         // fall due within sync latency plus one and a half slow periods of the pin
         chk("select late", 32'h0000_0001, 32'(n < 12));
      end
   endtask
   // ==========================================================
   // main sequence
   initial begin
      n_mismatch = 0;
      num_checks = 0;
      arst_n_i = 1'b0;
      {ovp, cmp_en, power_request_pin, clk_req, sel_pin} = 5'h00;
      cycles(10);
      arst_n_i <= 1'b1;
      t_reset();
      t_modes();
      t_current_limit_sel();
      t_reserved();
      t_ovp();
      t_spare_bits();
      t_osc();
      t_select();
      stop_test();
   end
endmodule
